//--- logic/acrw_top.sv
`timescale 1ns/1ps
`include "acrw_defines.svh"
module acrw_top
	import acrw_pkg::*;
#(
	parameter int unsigned CYC_BYPASS = `ACRW_CLK_HZ / `ACRW_BYPASS_HZ,
	parameter int unsigned CYC_FILTER = `ACRW_CLK_HZ / `ACRW_FILTER_HZ,
	parameter int unsigned CYC_WAKE   = `ACRW_CLK_HZ / `ACRW_WAKE_TOP_HZ
)
(
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [11:0]   paddr,
	input  wire logic [31:0]   pwdata,
	output logic      [31:0]   prdata,
	output logic               pready,
	output logic               pslverr,
	input  wire acrw_axes_type accel_in,
	output acrw_cfg_type       cfg_out,
	output logic               sample_tick,
	output logic               wake_tick,
	output logic               irq
);
	logic [7:0]    range_q;
	logic [7:0]    filter_q;
	logic [7:0]    wakerate_q;
	logic [7:0]    thresh_q;
	logic [7:0]    div_q;
	logic          lp_q;
	logic [2:0]    stat_q;
	logic [2:0]    mask_q;
	acrw_apb_type  apb_q;
	logic [9:0]    idx;
	logic          mapped;
	logic          wr_done;
	logic          rd_done;
	logic [31:0]   rd_d;
	logic          eff_fchoice;
	logic [31:0]   base_period;
	logic [31:0]   wake_period;
	logic          base_tick;
	logic          wake_raw;
	logic          wake_ok;
	logic [7:0]    div_cnt_q;
	logic          smp_ev;
	acrw_axes_type ref_q;
	logic [15:0]   limit;
	logic [24:0]   thr_prod;
	logic          motion_hit;
	logic          wom_ev;
	logic [2:0]    ev;

	// APB decode; unaligned or unknown addresses answer with an error
	assign idx     = paddr[11:2];
	assign mapped  = (paddr[1:0] == 2'b00) && idx >= `ACRW_IDX_RANGE
		&& idx <= `ACRW_IDX_STATE;
	assign wr_done = psel && penable && pready && pwrite;
	assign rd_done = psel && penable && pready && !pwrite;

	// One wait-free access cycle: pready rises in the cycle after setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			apb_q   <= ACRW_IDLE;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			unique case (apb_q)
				ACRW_IDLE: begin
					if (psel && !penable) begin
						apb_q   <= ACRW_ACCESS;
						pready  <= 1'b1;
						pslverr <= !mapped;
					end
				end
				ACRW_ACCESS: begin
					apb_q   <= ACRW_IDLE;
					pready  <= 1'b0;
					pslverr <= 1'b0;
				end
			endcase
		end
	end

	// Read mux with reserved positions forced to zero
	always_comb begin
		rd_d = 32'h0;
		unique case (idx)
			`ACRW_IDX_RANGE:    rd_d = {24'h0, range_q[7:3], 3'h0};
			`ACRW_IDX_FILTER:   rd_d = {28'h0, filter_q[3:0]};
			`ACRW_IDX_WAKERATE: rd_d = {28'h0, wakerate_q[3:0]};
			`ACRW_IDX_THRESH:   rd_d = {24'h0, thresh_q};
			`ACRW_IDX_CTRL:     rd_d = {31'h0, lp_q};
			`ACRW_IDX_DIV:      rd_d = {24'h0, div_q};
			`ACRW_IDX_STAT:     rd_d = {29'h0, stat_q};
			`ACRW_IDX_MASK:     rd_d = {29'h0, mask_q};
			`ACRW_IDX_STATE:    rd_d = {22'h0, cfg_out};
			default:            rd_d = 32'h0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (apb_q == ACRW_IDLE && psel && !penable) begin
			prdata <= (mapped && !pwrite) ? rd_d : 32'h0;
		end
	end

	// Config registers; reserved bits never stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			range_q    <= `ACRW_RST_RANGE;
			filter_q   <= `ACRW_RST_FILTER;
			wakerate_q <= `ACRW_RST_WAKERATE;
			thresh_q   <= `ACRW_RST_THRESH;
			div_q      <= `ACRW_RST_DIV;
			lp_q       <= 1'b0;
			mask_q     <= `ACRW_RST_MASK;
		end else if (wr_done && !pslverr) begin
			unique case (idx)
				`ACRW_IDX_RANGE:    range_q    <= {pwdata[7:3], 3'h0};
				`ACRW_IDX_FILTER:   filter_q   <= {4'h0, pwdata[3:0]};
				`ACRW_IDX_WAKERATE: wakerate_q <= {4'h0, pwdata[3:0]};
				`ACRW_IDX_THRESH:   thresh_q   <= pwdata[7:0];
				`ACRW_IDX_CTRL:     lp_q       <= pwdata[`ACRW_LP_BIT];
				`ACRW_IDX_DIV:      div_q      <= pwdata[7:0];
				`ACRW_IDX_MASK:     mask_q     <= pwdata[2:0];
				default: ;
			endcase
		end
	end

	// Effective choice is the stored bit inverted, low-power forces 0
	assign eff_fchoice = !lp_q && !filter_q[`ACRW_FCHB_BIT];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_out <= '0;
		end else begin
			cfg_out.x_axis_selftest_on  <= range_q[`ACRW_ST_X];
			cfg_out.y_axis_selftest_on  <= range_q[`ACRW_ST_Y];
			cfg_out.z_axis_selftest_on  <= range_q[`ACRW_ST_Z];
			cfg_out.accel_range_code    <= range_q[`ACRW_RANGE_MSB:`ACRW_RANGE_LSB];
			cfg_out.fchoice             <= eff_fchoice;
			// Code 7 aliases code 0; bypass ignores the field entirely
			cfg_out.lowpass_cutoff_code <= !eff_fchoice ? 3'h0
				: (filter_q[`ACRW_CUT_MSB:0] == `ACRW_CUT_ALIAS) ? 3'h0
				: filter_q[`ACRW_CUT_MSB:0];
			cfg_out.lowpower_on         <= lp_q;
		end
	end

	// Filter output rate: 4 kHz bypassed, 1 kHz filtered
	assign base_period = eff_fchoice ? CYC_FILTER : CYC_BYPASS;

	acrw_tick_gen u_base (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (!lp_q),
		.period  (base_period),
		.tick    (base_tick)
	);

	// Wake period doubles per code step below the top code
	assign wake_ok     = wakerate_q[`ACRW_WAKE_MSB:0] <= `ACRW_WAKE_TOP_CODE;
	assign wake_period = CYC_WAKE
		<< (`ACRW_WAKE_TOP_CODE - wakerate_q[`ACRW_WAKE_MSB:0]);

	// Reserved codes keep the part asleep rather than guessing a rate
	acrw_tick_gen u_wake (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (lp_q && wake_ok),
		.period  (wake_period),
		.tick    (wake_raw)
	);

	// Normal mode: one sample every (1 + divider) filter outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_q <= 8'h0;
		end else if (lp_q) begin
			div_cnt_q <= 8'h0;
		end else if (base_tick) begin
			div_cnt_q <= (div_cnt_q >= div_q) ? 8'h0 : div_cnt_q + 8'h1;
		end
	end

	// A tick already in flight when low power starts must not count
	assign smp_ev = base_tick && !lp_q && (div_cnt_q >= div_q);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sample_tick <= 1'b0;
			wake_tick   <= 1'b0;
		end else begin
			sample_tick <= smp_ev || (lp_q && wake_raw);
			wake_tick   <= lp_q && wake_raw;
		end
	end

	// Threshold in mg scaled to counts of the selected range
	assign thr_prod = 25'(thresh_q) * 25'(`ACRW_THR_MUL);
	assign limit    = 16'(thr_prod >> (`ACRW_THR_SHIFT + range_q[4:3]));

	acrw_motion_cmp u_cmp (
		.sample  (accel_in),
		.ref_val (ref_q),
		.limit   (limit),
		.hit     (motion_hit)
	);

	// Each taken sample becomes the next reference
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_q <= '0;
		end else if (sample_tick) begin
			ref_q <= accel_in;
		end
	end

	assign wom_ev = sample_tick && motion_hit;
	assign ev     = {wake_tick, sample_tick, wom_ev};

	// Sticky status, cleared by read; a same-cycle event wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_q <= 3'h0;
		end else if (rd_done && !pslverr && idx == `ACRW_IDX_STAT) begin
			// Only bits already reported are cleared; later events stay pending
			stat_q <= (stat_q & ~prdata[2:0]) | ev;
		end else begin
			stat_q <= stat_q | ev;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(stat_q & mask_q);
		end
	end

	// Helper: filter outputs since the last sample tick
	logic [8:0] gap_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_q <= 9'h0;
		end else if (lp_q || smp_ev) begin
			gap_q <= 9'h0;
		end else if (base_tick) begin
			gap_q <= gap_q + 9'h1;
		end
	end

	// Helper: a new divider may shorten or stretch the gap in progress
	logic div_new_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_new_q <= 1'b0;
		end else if (wr_done && idx == `ACRW_IDX_DIV) begin
			div_new_q <= 1'b1;
		end else if (smp_ev) begin
			div_new_q <= 1'b0;
		end
	end

	// Helper: cycles between filter outputs while the filter choice holds still
	logic [31:0] base_cyc_q;
	logic        base_fch_q;
	logic        base_steady_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			base_cyc_q    <= 32'h0;
			base_fch_q    <= 1'b0;
			base_steady_q <= 1'b0;
		end else if (lp_q || base_tick) begin
			base_cyc_q    <= 32'h1;
			base_fch_q    <= eff_fchoice;
			base_steady_q <= !lp_q;
		end else begin
			base_cyc_q    <= base_cyc_q + 32'h1;
			base_steady_q <= base_steady_q && (eff_fchoice == base_fch_q);
		end
	end

	a_range_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr_done && !pslverr && idx == `ACRW_IDX_RANGE
		|-> ##2 cfg_out.accel_range_code == $past(pwdata[4:3], 2))
		else $error("range code not applied");

	a_choice_inv: assert property (@(posedge pclk) disable iff (!presetn)
		!lp_q && $stable(filter_q) |=> cfg_out.fchoice == !$past(filter_q[3]))
		else $error("filter choice not inverted");

	a_bypass_rate: assert property (@(posedge pclk) disable iff (!presetn)
		base_tick && base_steady_q && !base_fch_q |-> base_cyc_q == CYC_BYPASS)
		else $error("bypass rate wrong");

	a_filter_rate: assert property (@(posedge pclk) disable iff (!presetn)
		base_tick && base_steady_q && base_fch_q |-> base_cyc_q == CYC_FILTER)
		else $error("filtered rate wrong");

	a_cutoff_alias: assert property (@(posedge pclk) disable iff (!presetn)
		eff_fchoice && filter_q[2:0] == 3'h7 |=> cfg_out.lowpass_cutoff_code == 3'h0)
		else $error("cutoff code 7 not aliased");

	a_div_spacing: assert property (@(posedge pclk) disable iff (!presetn)
		smp_ev && !div_new_q |-> gap_q == 9'(div_q))
		else $error("divider spacing wrong");

	a_lp_force: assert property (@(posedge pclk) disable iff (!presetn)
		lp_q |=> !cfg_out.fchoice && (sample_tick == wake_tick))
		else $error("low-power choice not forced");

	a_wake_resv: assert property (@(posedge pclk) disable iff (!presetn)
		(lp_q && !wake_ok) [*2] |=> !wake_tick)
		else $error("reserved wake code woke");

	a_wom_flag: assert property (@(posedge pclk) disable iff (!presetn)
		wom_ev |=> stat_q[`ACRW_STAT_WOM])
		else $error("wake-on-motion flag lost");

	a_rsvd_read: assert property (@(posedge pclk) disable iff (!presetn)
		rd_done && idx == `ACRW_IDX_RANGE |-> prdata[2:0] == 3'h0)
		else $error("reserved bits read nonzero");

	a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
		##1 irq == |($past(stat_q) & $past(mask_q)))
		else $error("interrupt level mismatch");

	c_cfg_write: cover property (@(posedge pclk) disable iff (!presetn)
		wr_done && idx == `ACRW_IDX_FILTER);
	c_lp_wake:   cover property (@(posedge pclk) disable iff (!presetn)
		wake_tick);
	c_wom_irq:   cover property (@(posedge pclk) disable iff (!presetn)
		wom_ev ##[1:3] irq);
	c_div_sample: cover property (@(posedge pclk) disable iff (!presetn)
		smp_ev && div_q != 8'h00);
	c_stat_clear: cover property (@(posedge pclk) disable iff (!presetn)
		rd_done && idx == `ACRW_IDX_STAT && stat_q[`ACRW_STAT_WOM]);
endmodule // acrw_top

//--- logic/acrw_defines.svh
`ifndef ACRW_DEFINES_SVH
`define ACRW_DEFINES_SVH

// Register indexes; byte address is four times the index
`define ACRW_IDX_RANGE      10'h01C
`define ACRW_IDX_FILTER     10'h01D
`define ACRW_IDX_WAKERATE   10'h01E
`define ACRW_IDX_THRESH     10'h01F
`define ACRW_IDX_CTRL       10'h020
`define ACRW_IDX_DIV        10'h021
`define ACRW_IDX_STAT       10'h022
`define ACRW_IDX_MASK       10'h023
`define ACRW_IDX_STATE      10'h024

// Reset values
`define ACRW_RST_RANGE      8'h00
`define ACRW_RST_FILTER     8'h00
`define ACRW_RST_WAKERATE   8'h00
`define ACRW_RST_THRESH     8'h00
`define ACRW_RST_DIV        8'h00
`define ACRW_RST_MASK       3'h0

// Field positions
`define ACRW_ST_X           7
`define ACRW_ST_Y           6
`define ACRW_ST_Z           5
`define ACRW_RANGE_MSB      4
`define ACRW_RANGE_LSB      3
`define ACRW_FCHB_BIT       3
`define ACRW_CUT_MSB        2
`define ACRW_WAKE_MSB       3
`define ACRW_LP_BIT         0
`define ACRW_STAT_WOM       0
`define ACRW_STAT_SAMPLE    1
`define ACRW_STAT_WAKE      2

// Timing
`define ACRW_CLK_HZ         50000000
`define ACRW_BYPASS_HZ      4000
`define ACRW_FILTER_HZ      1000
`define ACRW_WAKE_TOP_HZ    500
`define ACRW_WAKE_TOP_CODE  4'hB
`define ACRW_CUT_ALIAS      3'h7

// Threshold scale: 4 mg per count, 16384 counts per g at the finest range
`define ACRW_MG_PER_COUNT   4
`define ACRW_THR_MUL        17'h10625
`define ACRW_THR_SHIFT      10

`endif

//--- logic/acrw_pkg.sv
package acrw_pkg;

	typedef struct packed {
		logic       x_axis_selftest_on;
		logic       y_axis_selftest_on;
		logic       z_axis_selftest_on;
		logic [1:0] accel_range_code;
		logic       fchoice;
		logic [2:0] lowpass_cutoff_code;
		logic       lowpower_on;
	} acrw_cfg_type;

	typedef struct packed {
		logic [2:0][15:0] axis;
	} acrw_axes_type;

	typedef enum logic [1:0] {
		ACRW_IDLE   = 2'b00,
		ACRW_ACCESS = 2'b01
	} acrw_apb_type;

endpackage

//--- logic/acrw_tick_gen.sv
`timescale 1ns/1ps
module acrw_tick_gen
	import acrw_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        run,
	input  wire logic [31:0] period,
	output logic             tick
);
	logic [31:0] cnt_q;

	// Restart on stop so a new period starts cleanly
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 32'h0;
			tick  <= 1'b0;
		end else if (!run) begin
			cnt_q <= 32'h0;
			tick  <= 1'b0;
		end else if (cnt_q >= period - 32'h1) begin
			cnt_q <= 32'h0;
			tick  <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 32'h1;
			tick  <= 1'b0;
		end
	end
endmodule // acrw_tick_gen

//--- logic/acrw_motion_cmp.sv
`timescale 1ns/1ps
module acrw_motion_cmp
	import acrw_pkg::*;
(
	input  wire acrw_axes_type sample,
	input  wire acrw_axes_type ref_val,
	input  wire logic [15:0]   limit,
	output logic               hit
);
	logic [2:0] over;

	// Per-axis distance from the reference sample
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_axis
			logic signed [16:0] diff;
			logic        [16:0] mag;
			assign diff    = $signed({sample.axis[g][15], sample.axis[g]})
				- $signed({ref_val.axis[g][15], ref_val.axis[g]});
			assign mag     = diff[16] ? 17'(-diff) : 17'(diff);
			assign over[g] = mag > {1'b0, limit};
		end
	endgenerate

	assign hit = |over;
endmodule // acrw_motion_cmp

//--- verif/tb_acrw_top.sv
`timescale 1ns/1ps
module tb_acrw_top;
	import acrw_pkg::*;

	typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e;} acrw_reg_row_type;
	typedef struct {logic [7:0] f; logic [7:0] v; logic lp; logic [3:0] c; bit w; int g;}
		acrw_rate_row_type;

	localparam int LIM = 200;

	logic          pclk     = 1'b0;
	logic          presetn  = 1'b0;
	logic          psel     = 1'b0;
	logic          penable  = 1'b0;
	logic          pwrite   = 1'b0;
	logic [11:0]   paddr    = '0;
	logic [31:0]   pwdata   = '0;
	acrw_axes_type accel_in = '0;
	logic [31:0]   prdata;
	logic [31:0]   rd;
	logic          pready;
	logic          pslverr;
	logic          err;
	acrw_cfg_type  cfg_out;
	logic          sample_tick;
	logic          wake_tick;
	logic          irq;
	int            n_fail;
	int            n_compared;
	int            g;
	logic [2:0]    cut_e;

	// Reserved bits are written as ones so a missing mask shows up
	acrw_reg_row_type regs [7] = '{
		'{12'h070, 32'hFFFF_FFFF, 32'h0000_00F8},
		'{12'h070, 32'h0000_0017, 32'h0000_0010},
		'{12'h074, 32'hFFFF_FFFF, 32'h0000_000F},
		'{12'h074, 32'h0000_0035, 32'h0000_0005},
		'{12'h078, 32'hFFFF_FFF3, 32'h0000_0003},
		'{12'h07C, 32'hFFFF_FFFF, 32'h0000_00FF},
		'{12'h07C, 32'h0000_0104, 32'h0000_0004}
	};

	// Small periods: bypass 5, filter 10, top wake rate 4 cycles
	acrw_rate_row_type rates [9] = '{
		'{8'h08, 8'h00, 1'b0, 4'h0, 1'b0, 5},
		'{8'h0D, 8'h02, 1'b0, 4'h0, 1'b0, 15},
		'{8'h03, 8'h00, 1'b0, 4'h0, 1'b0, 10},
		'{8'h00, 8'h01, 1'b0, 4'h0, 1'b0, 20},
		'{8'h07, 8'h00, 1'b0, 4'h0, 1'b0, 10},
		'{8'h00, 8'h00, 1'b1, 4'hB, 1'b1, 4},
		'{8'h02, 8'h00, 1'b1, 4'hA, 1'b1, 8},
		'{8'h00, 8'h00, 1'b1, 4'h9, 1'b1, 16},
		'{8'h00, 8'h00, 1'b1, 4'hC, 1'b1, LIM}
	};

	acrw_top #(
		.CYC_BYPASS (5),
		.CYC_FILTER (10),
		.CYC_WAKE   (4)
	) i_acrw_top (
		.pclk        (pclk),
		.presetn     (presetn),
		.psel        (psel),
		.penable     (penable),
		.pwrite      (pwrite),
		.paddr       (paddr),
		.pwdata      (pwdata),
		.prdata      (prdata),
		.pready      (pready),
		.pslverr     (pslverr),
		.accel_in    (accel_in),
		.cfg_out     (cfg_out),
		.sample_tick (sample_tick),
		.wake_tick   (wake_tick),
		.irq         (irq)
	);

	initial begin
		forever #10 pclk = ~pclk;
	end

	task automatic chk(input string name, input logic [31:0] e, input logic [31:0] s);
		n_compared++;
		if (s !== e) begin
			$display("Error %s expected %h seen %h", name, e, s);
			n_fail++;
		end
	endtask

	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Waits on pready with a bound rather than trusting a fixed latency
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk("pready", 32'h1, 32'(pready));
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rd, err);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input string name);
		apb(1'b0, a, 32'h0, rd, err);
		chk(name, e, rd);
	endtask

	// First gap after a change may be stale, callers measure twice
	task automatic gap(input bit w, output int n);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while ((w ? wake_tick : sample_tick) !== 1'b1 && n < LIM);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while ((w ? wake_tick : sample_tick) !== 1'b1 && n < LIM);
	endtask

	task automatic mstep(input logic [15:0] v, input logic ei, input logic es);
		@(posedge pclk);
		accel_in.axis[1] <= v;
		repeat (20) @(posedge pclk);
		chk("irq", 32'(ei), 32'(irq));
		apb(1'b0, 12'h088, 32'h0, rd, err);
		chk("motion status", 32'(es), 32'(rd[0]));
		repeat (3) @(posedge pclk);
		chk("irq after clear", 32'h0, 32'(irq));
	endtask

	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			rd_chk(12'h070 + 12'(4 * i), 32'h0, "reset value");
		end
		foreach (regs[i]) begin
			wr(regs[i].a, regs[i].d);
			rd_chk(regs[i].a, regs[i].e, "readback");
		end
		for (int c = 0; c < 4; c++) begin
			wr(12'h070, (32'(c) << 3) | 32'h0000_00A0);
			repeat (2) @(posedge pclk);
			chk("range code", 32'(c), 32'(cfg_out.accel_range_code));
			chk("selftest", 32'h5, 32'({cfg_out.x_axis_selftest_on,
				cfg_out.y_axis_selftest_on, cfg_out.z_axis_selftest_on}));
		end
		foreach (rates[i]) begin
			wr(12'h074, 32'(rates[i].f));
			wr(12'h084, 32'(rates[i].v));
			wr(12'h080, 32'(rates[i].lp));
			wr(12'h078, 32'(rates[i].c));
			gap(rates[i].w, g);
			gap(rates[i].w, g);
			chk("tick gap", 32'(rates[i].g), 32'(g));
			chk("fchoice", 32'(!rates[i].lp && !rates[i].f[3]), 32'(cfg_out.fchoice));
			// Bypass hides the cutoff; code 7 gives the same filter as code 0
			cut_e = (rates[i].lp || rates[i].f[3] || rates[i].f[2:0] == 3'h7) ? 3'h0
				: rates[i].f[2:0];
			chk("cutoff", 32'(cut_e), 32'(cfg_out.lowpass_cutoff_code));
		end
		// Threshold 1 is 65 counts at 2 g and 32 counts at 4 g
		wr(12'h074, 32'h8);
		wr(12'h080, 32'h0);
		wr(12'h070, 32'h0);
		wr(12'h07C, 32'h1);
		wr(12'h08C, 32'h1);
		apb(1'b0, 12'h088, 32'h0, rd, err);
		mstep(16'd50, 1'b0, 1'b0);
		mstep(16'd150, 1'b1, 1'b1);
		wr(12'h08C, 32'h0);
		mstep(16'd0, 1'b0, 1'b1);
		wr(12'h070, 32'h8);
		wr(12'h08C, 32'h1);
		mstep(16'd50, 1'b1, 1'b1);
		apb(1'b1, 12'h07D, 32'hFF, rd, err);
		chk("unaligned error", 32'h1, 32'(err));
		rd_chk(12'h07C, 32'h1, "after unaligned write");
		apb(1'b0, 12'h200, 32'h0, rd, err);
		chk("unmapped error", 32'h1, 32'(err));
		chk("unmapped data", 32'h0, rd);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(12'h07C, 32'h0, "threshold after reset");
		// Stored choice bit resets to 0, so the effective choice reads 1
		chk("cfg after reset", 32'h10, 32'(cfg_out));
		final_report;
	end

	initial begin
		repeat (60000) @(posedge pclk);
		n_fail++;
		final_report;
	end

endmodule // tb_acrw_top
